/* File: src/clock_power_event_pkg.sv */
// constants for the clock and power event unit
// assumes a 50 MHz bus clock and active-high synchronous reset
package clock_power_event_pkg;
  localparam int RATE_W = 8;
  localparam logic [7:0] RATE_RESET = 8'h00;
  localparam logic [2:0] WD_TIMEOUT_RESET = 3'h0;
  localparam logic WD_WINDOW_RESET = 1'b0;
  localparam int PRESCALE_W = 4;
  // periodic period in ticks of the selected source: (rate + 1) << PRESCALE_SHIFT
  localparam int PRESCALE_SHIFT = 4;
  localparam int MODE_W = 2;
  // bit positions of the write-one clear mask
  localparam int FLAG_PERIODIC_BIT = 0;
  localparam int FLAG_LOCK_BIT = 1;
  localparam int FLAG_OSC_BIT = 2;
  localparam int FLAG_LV_BIT = 3;
  localparam logic PLL_SELECT_RESET = 1'b1;
endpackage

/* File: src/clock_power_event_unit.sv */
// periodic timer, lock, oscillator and low-voltage event flags, watchdog write-once
// assumes all status and tick inputs are synchronous to core_clk
`timescale 1ns/1ns

// Overview of operation
// - timer ticks from selected reference or oscillator
// - in stop, run only in pseudo-stop with oscillator
// - timeout sets flag, next period starts immediately
// - periodic request at selected rate when enabled
// - rate register write restarts the period
// - lock change either way sets lock flag
// - writing one clears lock flag
// - lock request gated by its enable
// - qualified stays zero while oscillator disabled
// - filter setting zero passes clock unfiltered
// - unfiltered qualification follows lock set
// - any qualified toggle sets oscillator flag
// - stop or disable changes are flagged too
// - lock loss clears qualified status
// - oscillator request gated by its enable
// - low-voltage status follows supply thresholds in FULL_PERFORMANCE_MODE
// - low-voltage change sets flag, gated request
// - watchdog config writable once then locked
// - bypass mode: qualification loss forces PLL select
module clock_power_event_unit
  import clock_power_event_pkg::*;
#(
  parameter int RATE_WIDTH = RATE_W
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic internal_ref_tick,
  input wire logic oscillator_tick,
  input wire logic oscillator_clock_in,
  input wire logic periodic_osc_select,
  input wire logic stop_mode,
  input wire logic pseudo_stop_enable,
  input wire logic periodic_run_in_stop,
  input wire logic periodic_irq_enable,
  input wire logic rate_write,
  input wire logic [RATE_WIDTH-1:0] rate_wdata,
  input wire logic pll_lock,
  input wire logic pll_config_change,
  input wire logic lock_irq_enable,
  input wire logic ext_osc_enable,
  input wire logic [4:0] osc_spike_filter_setting,
  input wire logic osc_filter_qualified,
  input wire logic osc_irq_enable,
  input wire logic full_stop,
  input wire logic pll_bypass_mode,
  input wire logic pll_select_write,
  input wire logic pll_select_wdata,
  input wire logic full_performance_mode,
  input wire logic supply_below_assert,
  input wire logic supply_above_deassert,
  input wire logic low_voltage_irq_enable,
  input wire logic flag_clear_write,
  input wire logic [3:0] flag_clear_mask,
  input wire logic normal_mode,
  input wire logic watchdog_write,
  input wire logic watchdog_window_wdata,
  input wire logic [2:0] watchdog_timeout_wdata,
  output logic [RATE_WIDTH-1:0] periodic_rate_reg,
  output logic periodic_timeout_flag,
  output logic periodic_irq,
  output logic lock_status,
  output logic lock_change_flag,
  output logic lock_irq,
  output logic osc_qualified_status,
  output logic osc_status_change_flag,
  output logic osc_irq,
  output logic filtered_osc_clock,
  output logic low_voltage_status,
  output logic low_voltage_change_flag,
  output logic low_voltage_irq,
  output logic pll_clock_select,
  output logic watchdog_window_enable,
  output logic [2:0] watchdog_timeout_select,
  output logic watchdog_locked
);

  if (RATE_WIDTH < 1 || RATE_WIDTH > 16) begin : g_bad_width
    $error("RATE_WIDTH out of range");
  end

  // a zero shift would make the period only rate + 1 ticks and defeat the prescaler
  if (PRESCALE_SHIFT < 1 || PRESCALE_SHIFT > 8) begin : g_bad_shift
    $error("PRESCALE_SHIFT out of range");
  end

  localparam int CNT_W = RATE_WIDTH + PRESCALE_SHIFT;

  // periodic timer
  logic [CNT_W-1:0] periodic_count;
  logic [CNT_W-1:0] periodic_limit;
  logic periodic_tick;
  logic periodic_running;
  logic periodic_step;
  logic periodic_expire;

  // status history and change detection
  logic lock_seen;
  logic lock_changed;
  logic next_qualified;
  logic qual_seen;
  logic qual_changed;
  logic qual_lost;
  logic lv_seen;
  logic lv_changed;

  // write-one clear strobes, one per flag
  logic clear_periodic;
  logic clear_lock;
  logic clear_osc;
  logic clear_lv;
  logic watchdog_accept;

  // mask bit positions are shared with software through the package
  assign clear_periodic = flag_clear_write && flag_clear_mask[FLAG_PERIODIC_BIT];
  assign clear_lock = flag_clear_write && flag_clear_mask[FLAG_LOCK_BIT];
  assign clear_osc = flag_clear_write && flag_clear_mask[FLAG_OSC_BIT];
  assign clear_lv = flag_clear_write && flag_clear_mask[FLAG_LV_BIT];

  // low prescale bits all ones, so a period is (rate + 1) << shift ticks
  assign periodic_limit = {periodic_rate_reg, {PRESCALE_SHIFT{1'b1}}};
  assign periodic_tick = periodic_osc_select ? oscillator_tick : internal_ref_tick;
  // outside stop always runs; in stop only the pseudo-stop oscillator case keeps going
  assign periodic_running = !stop_mode ||
    (pseudo_stop_enable && periodic_osc_select && periodic_run_in_stop);
  assign periodic_step = periodic_running && periodic_tick;
  assign periodic_expire = periodic_step && (periodic_count == periodic_limit);

  assign lock_changed = lock_status != lock_seen;
  assign qual_changed = osc_qualified_status != qual_seen;
  assign qual_lost = qual_seen && !osc_qualified_status;
  assign lv_changed = low_voltage_status != lv_seen;
  assign watchdog_accept = watchdog_write && normal_mode && !watchdog_locked;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      periodic_rate_reg <= RATE_WIDTH'(RATE_RESET);
    end else if (rate_write) begin
      periodic_rate_reg <= rate_wdata;
    end
  end

  // a rate write restarts the period even in the cycle of a timeout
  always_ff @(posedge core_clk) begin
    if (reset) begin
      periodic_count <= '0;
    end else if (rate_write) begin
      periodic_count <= '0;
    end else if (periodic_expire) begin
      periodic_count <= '0;
    end else if (periodic_step) begin
      periodic_count <= periodic_count + 1'b1;
    end
  end

  // set wins over a simultaneous write-one clear on every flag
  always_ff @(posedge core_clk) begin
    if (reset) begin
      periodic_timeout_flag <= 1'b0;
    end else if (periodic_expire) begin
      periodic_timeout_flag <= 1'b1;
    end else if (clear_periodic) begin
      periodic_timeout_flag <= 1'b0;
    end
  end

  // config change drops lock at once rather than waiting for the loop to notice
  always_ff @(posedge core_clk) begin
    if (reset) begin
      lock_status <= 1'b0;
    end else begin
      lock_status <= pll_lock && !pll_config_change;
    end
  end

  // seen copies lag their status by one edge, so a change shows for one cycle
  always_ff @(posedge core_clk) begin
    if (reset) begin
      lock_seen <= 1'b0;
    end else begin
      lock_seen <= lock_status;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      lock_change_flag <= 1'b0;
    end else if (lock_changed) begin
      lock_change_flag <= 1'b1;
    end else if (clear_lock) begin
      lock_change_flag <= 1'b0;
    end
  end

  // with filter off qualification waits on lock; with filter on the filter's verdict
  // also needs lock since the filter runs from the PLL
  always_comb begin
    next_qualified = 1'b0;
    if (ext_osc_enable && !full_stop && lock_status && !pll_config_change) begin
      if (osc_spike_filter_setting == 5'h00) begin
        next_qualified = 1'b1;
      end else begin
        next_qualified = osc_filter_qualified;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      osc_qualified_status <= 1'b0;
    end else begin
      osc_qualified_status <= next_qualified;
    end
  end

  // qualification history feeds both the flag and the bypass fallback
  always_ff @(posedge core_clk) begin
    if (reset) begin
      qual_seen <= 1'b0;
    end else begin
      qual_seen <= osc_qualified_status;
    end
  end

  // registered pass-through; only the unfiltered case is modelled here
  always_ff @(posedge core_clk) begin
    if (reset) begin
      filtered_osc_clock <= 1'b0;
    end else begin
      filtered_osc_clock <= ext_osc_enable && oscillator_clock_in;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      osc_status_change_flag <= 1'b0;
    end else if (qual_changed) begin
      osc_status_change_flag <= 1'b1;
    end else if (clear_osc) begin
      osc_status_change_flag <= 1'b0;
    end
  end

  // status holds outside full performance mode; between thresholds it keeps its value
  always_ff @(posedge core_clk) begin
    if (reset) begin
      low_voltage_status <= 1'b0;
    end else if (full_performance_mode && supply_below_assert) begin
      low_voltage_status <= 1'b1;
    end else if (full_performance_mode && supply_above_deassert) begin
      low_voltage_status <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      lv_seen <= 1'b0;
    end else begin
      lv_seen <= low_voltage_status;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      low_voltage_change_flag <= 1'b0;
    end else if (lv_changed) begin
      low_voltage_change_flag <= 1'b1;
    end else if (clear_lv) begin
      low_voltage_change_flag <= 1'b0;
    end
  end

  // requests registered so each is flag and enable one cycle later
  always_ff @(posedge core_clk) begin
    if (reset) begin
      periodic_irq <= 1'b0;
    end else begin
      periodic_irq <= periodic_timeout_flag && periodic_irq_enable;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      lock_irq <= 1'b0;
    end else begin
      lock_irq <= lock_change_flag && lock_irq_enable;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      osc_irq <= 1'b0;
    end else begin
      osc_irq <= osc_status_change_flag && osc_irq_enable;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      low_voltage_irq <= 1'b0;
    end else begin
      low_voltage_irq <= low_voltage_change_flag && low_voltage_irq_enable;
    end
  end

  // pll select resets to one; loss of qualification in bypass forces it back
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pll_clock_select <= PLL_SELECT_RESET;
    end else if (pll_bypass_mode && qual_lost) begin
      pll_clock_select <= 1'b1;
    end else if (pll_select_write) begin
      pll_clock_select <= pll_select_wdata;
    end
  end

  // a runaway program cannot retune the watchdog once software has written it
  always_ff @(posedge core_clk) begin
    if (reset) begin
      watchdog_window_enable <= WD_WINDOW_RESET;
      watchdog_timeout_select <= WD_TIMEOUT_RESET;
    end else if (watchdog_accept) begin
      watchdog_window_enable <= watchdog_window_wdata;
      watchdog_timeout_select <= watchdog_timeout_wdata;
    end
  end

  // only a reset unlocks; software has no way back
  always_ff @(posedge core_clk) begin
    if (reset) begin
      watchdog_locked <= 1'b0;
    end else if (watchdog_accept) begin
      watchdog_locked <= 1'b1;
    end
  end

endmodule

/* File: sim/clock_power_event_unit_properties.sv */
// checker for the clock and power event unit, sees only its ports
// assumes the bind in the testbench top file connects every pin by name
`timescale 1ns/1ns
module clock_power_event_unit_properties (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic lock_status,
  input wire logic lock_change_flag,
  input wire logic lock_irq,
  input wire logic lock_irq_enable,
  input wire logic ext_osc_enable,
  input wire logic osc_qualified_status,
  input wire logic osc_status_change_flag,
  input wire logic osc_irq,
  input wire logic osc_irq_enable,
  input wire logic low_voltage_status,
  input wire logic low_voltage_change_flag,
  input wire logic full_performance_mode,
  input wire logic supply_below_assert,
  input wire logic flag_clear_write,
  input wire logic [3:0] flag_clear_mask,
  input wire logic periodic_irq,
  input wire logic periodic_timeout_flag,
  input wire logic periodic_irq_enable,
  input wire logic pll_bypass_mode,
  input wire logic pll_clock_select,
  input wire logic watchdog_locked,
  input wire logic watchdog_window_enable,
  input wire logic [2:0] watchdog_timeout_select
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // a clear in the same cycle as a fresh change must lose, so exclude that case
  sequence s_lock_clear;
    lock_change_flag && flag_clear_write && flag_clear_mask[1] && $stable(lock_status);
  endsequence
  property p_lock_set; $changed(lock_status) |=> lock_change_flag; endproperty
  a_lock_set: assert property (p_lock_set) else $error("lock flag missed");
  property p_lock_clr; s_lock_clear |=> !lock_change_flag; endproperty
  a_lock_clr: assert property (p_lock_clr) else $error("lock flag kept");
  property p_lock_irq; lock_irq |-> $past(lock_change_flag && lock_irq_enable); endproperty
  a_lock_irq: assert property (p_lock_irq) else $error("lock request ungated");
  property p_osc_off; !ext_osc_enable |=> !osc_qualified_status; endproperty
  a_osc_off: assert property (p_osc_off) else $error("qualified while off");
  property p_qual; osc_qualified_status |-> $past(lock_status); endproperty
  a_qual: assert property (p_qual) else $error("qualified without lock");
  property p_osc_set; $changed(osc_qualified_status) |=> osc_status_change_flag; endproperty
  a_osc_set: assert property (p_osc_set) else $error("osc flag missed");
  property p_osc_irq;
    osc_irq |-> $past(osc_status_change_flag && osc_irq_enable);
  endproperty
  a_osc_irq: assert property (p_osc_irq) else $error("osc request ungated");
  property p_lv; full_performance_mode && supply_below_assert |=> low_voltage_status; endproperty
  a_lv: assert property (p_lv) else $error("low voltage missed");
  property p_lv_set; $changed(low_voltage_status) |=> low_voltage_change_flag; endproperty
  a_lv_set: assert property (p_lv_set) else $error("lv flag missed");
  property p_per_irq;
    periodic_irq |-> $past(periodic_timeout_flag && periodic_irq_enable);
  endproperty
  a_per_irq: assert property (p_per_irq) else $error("periodic request ungated");
  property p_bypass; $fell(osc_qualified_status) && pll_bypass_mode |-> ##[0:2] pll_clock_select;
  endproperty
  a_bypass: assert property (p_bypass) else $error("pll select not forced");
  property p_wd;
    watchdog_locked |=> $stable(watchdog_timeout_select) && $stable(watchdog_window_enable);
  endproperty
  a_wd: assert property (p_wd) else $error("watchdog config changed");
endmodule

/* File: sim/clock_power_event_unit_tb.sv */
// testbench for the clock and power event unit, inputs driven at falling edges
// assumes the package and the properties checker are compiled first
`timescale 1ns/1ns
module clock_power_event_unit_tb;
  import clock_power_event_pkg::*;
  logic core_clk = 0, reset = 1, internal_ref_tick = 1, oscillator_tick = 0;
  logic oscillator_clock_in = 0, periodic_osc_select = 0, stop_mode = 0;
  logic pseudo_stop_enable = 0, periodic_run_in_stop = 0, periodic_irq_enable = 1;
  logic rate_write = 0, pll_lock = 0, pll_config_change = 0, lock_irq_enable = 1;
  logic ext_osc_enable = 0, osc_filter_qualified = 0, osc_irq_enable = 1, full_stop = 0;
  logic pll_bypass_mode = 0, pll_select_write = 0, pll_select_wdata = 0;
  logic full_performance_mode = 1, supply_below_assert = 0, supply_above_deassert = 1;
  logic low_voltage_irq_enable = 1, flag_clear_write = 0, normal_mode = 1;
  logic watchdog_write = 0, watchdog_window_wdata = 0;
  logic [7:0] rate_wdata = 8'h00, periodic_rate_reg;
  logic [4:0] osc_spike_filter_setting = 5'h00;
  logic [3:0] flag_clear_mask = 4'h0;
  logic [2:0] watchdog_timeout_wdata = 3'h0, watchdog_timeout_select;
  logic periodic_timeout_flag, periodic_irq, lock_status, lock_change_flag, lock_irq;
  logic osc_qualified_status, osc_status_change_flag, osc_irq, filtered_osc_clock;
  logic low_voltage_status, low_voltage_change_flag, low_voltage_irq, pll_clock_select;
  logic watchdog_window_enable, watchdog_locked;
  int errors = 0, n_tests = 0;
  clock_power_event_unit dut (.*);
  initial forever #10 core_clk = ~core_clk;
  task cyc(input int n); repeat (n) @(negedge core_clk); endtask
  task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask
  task clr(input logic [3:0] m);
    flag_clear_mask = m; flag_clear_write = 1; cyc(1); flag_clear_write = 0; cyc(1);
  endtask
  task wr_rate(); rate_write = 1; cyc(1); rate_write = 0; endtask
  task conclude();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge core_clk);
    errors++;
    conclude();
  end
  initial begin
    cyc(10); reset = 0; cyc(1);
    chk("pll_select", 8'h01, pll_clock_select);
    pll_lock = 1; cyc(3);
    chk("lock_flag", 8'h01, lock_change_flag);
    chk("lock_irq", 8'h01, lock_irq);
    clr(4'h2); chk("lock_flag", 8'h00, lock_change_flag);
    chk("qualified", 8'h00, osc_qualified_status);
    ext_osc_enable = 1; oscillator_clock_in = 1; cyc(3);
    chk("qualified", 8'h01, osc_qualified_status);
    chk("osc_irq", 8'h01, osc_irq);
    chk("filtered", 8'h01, filtered_osc_clock);
    pll_config_change = 1; cyc(2); pll_config_change = 0;
    chk("qualified", 8'h00, osc_qualified_status);
    cyc(3); clr(4'h6); lock_irq_enable = 0; pll_lock = 0; cyc(3);
    chk("lock_flag", 8'h01, lock_change_flag);
    chk("lock_irq", 8'h00, lock_irq);
    pll_lock = 1; pll_bypass_mode = 1; pll_select_write = 1; cyc(1); pll_select_write = 0;
    cyc(4); chk("pll_select", 8'h00, pll_clock_select);
    ext_osc_enable = 0; cyc(4);
    chk("pll_select", 8'h01, pll_clock_select);
    chk("osc_flag", 8'h01, osc_status_change_flag);
    supply_below_assert = 1; supply_above_deassert = 0; cyc(3);
    chk("lv_status", 8'h01, low_voltage_status);
    chk("lv_irq", 8'h01, low_voltage_irq);
    wr_rate(); clr(4'h1); cyc(8); wr_rate(); cyc(15);
    chk("rate", 8'h00, periodic_rate_reg);
    chk("timeout", 8'h00, periodic_timeout_flag);
    cyc(5); chk("periodic_irq", 8'h01, periodic_irq);
    periodic_osc_select = 1; wr_rate(); clr(4'h1); cyc(40);
    chk("timeout", 8'h00, periodic_timeout_flag);
    stop_mode = 1; oscillator_tick = 1; cyc(40);
    chk("timeout", 8'h00, periodic_timeout_flag);
    pseudo_stop_enable = 1; periodic_run_in_stop = 1; cyc(20);
    chk("timeout", 8'h01, periodic_timeout_flag);
    watchdog_window_wdata = 1; watchdog_timeout_wdata = 3'h5;
    watchdog_write = 1; cyc(1); watchdog_write = 0; cyc(1);
    watchdog_window_wdata = 0; watchdog_timeout_wdata = 3'h2;
    watchdog_write = 1; cyc(1); watchdog_write = 0; cyc(1);
    chk("wd_timeout", 8'h05, watchdog_timeout_select);
    chk("wd_window", 8'h01, watchdog_window_enable);
    chk("wd_locked", 8'h01, watchdog_locked);
    osc_spike_filter_setting = 5'h03; ext_osc_enable = 1; cyc(3);
    chk("qualified", 8'h00, osc_qualified_status);
    osc_filter_qualified = 1; cyc(2);
    chk("qualified", 8'h01, osc_qualified_status);
    full_stop = 1; cyc(3);
    chk("qualified", 8'h00, osc_qualified_status);
    clr(4'h8); chk("lv_flag", 8'h00, low_voltage_change_flag);
    supply_below_assert = 0; supply_above_deassert = 1; cyc(2);
    chk("lv_status", 8'h00, low_voltage_status);
    chk("lv_flag", 8'h01, low_voltage_change_flag);
    conclude();
  end
endmodule
bind clock_power_event_unit clock_power_event_unit_properties props (.*);
